/* File: src/emi_lane_map.sv */
// Byte lane strobes and write data placement for one access
`timescale 1ns/1ps
module emi_lane_map
   import emi_pkg::*;
(
   input  wire logic [1:0]  size,
   input  wire logic [1:0]  addr_lo,
   input  wire logic        narrow,
   input  wire logic [31:0] wdata,
   output logic      [3:0]  strobe_n,
   output logic      [3:0]  lane_oe,
   output logic      [31:0] wdata_lane
);

   wire logic [7:0] sel_byte;
   wire logic [3:0] wide_strobe_n;
   wire logic [3:0] byte_strobe_n;

   // Lane 0 is the top byte of the bus, so big-endian byte order
   assign sel_byte      = 8'(wdata >> {~addr_lo, 3'h0});
   assign byte_strobe_n = ~(4'h1 << addr_lo);
   assign wide_strobe_n = (size == SIZE_WORD) ? 4'h0 :
                          (size == SIZE_HALF) ? (addr_lo[1] ? 4'h3 : 4'hc) :
                          (size == SIZE_BYTE) ? byte_strobe_n : 4'hf;

   // A narrow area only ever uses the top lane
   assign strobe_n   = narrow ? 4'he : wide_strobe_n;
   assign wdata_lane = narrow ? {sel_byte, 24'h000000} : wdata;
   assign lane_oe    = {~strobe_n[0], ~strobe_n[1], ~strobe_n[2], ~strobe_n[3]};

endmodule

/* File: src/emi_pin_if.sv */
// External memory pin interface: PROM, SRAM, I/O and SDRAM access sequencer
`timescale 1ns/1ps
module emi_pin_if
   import emi_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire emi_cfg_t    cfg,
   input  wire logic        req_valid,
   input  wire emi_req_t    req,
   output logic             req_ready,
   output logic             rsp_valid,
   output emi_rsp_t         rsp,
   output logic             gpio_owns_low_lanes,
   output logic [27:0]      address_out,
   input  wire logic [31:0] data_in,
   output logic [31:0]      data_out,
   output logic [3:0]       data_lane_oe,
   input  wire logic [7:0]  check_bit_lines_in,
   output logic [7:0]       check_bit_lines_out,
   output logic             check_bit_lines_oe,
   output logic             output_enable_n,
   output logic             read_strobe,
   output logic             write_strobe_n,
   output logic [3:0]       byte_lane_write_strobe_n,
   input  wire logic        access_ready_n,
   input  wire logic        bus_exception_n,
   output logic [1:0]       boot_rom_select_n,
   output logic [4:0]       static_ram_bank_select_n,
   output logic [4:0]       static_ram_bank_oe_n,
   output logic             io_area_select_n,
   output logic             sync_dram_clock_out,
   output logic [1:0]       sync_dram_bank_select_n,
   output logic             sync_dram_row_strobe_n,
   output logic             sync_dram_column_strobe_n,
   output logic             sync_dram_write_n,
   output logic [3:0]       sync_dram_byte_mask
);

   localparam emi_pins_t PINS_IDLE = '{
      addr: 28'h0000000, oe_n: 1'b1, read: 1'b0, write_n: 1'b1, lane_we_n: 4'hf,
      rom_sel_n: 2'h3, ram_sel_n: 5'h1f, ram_oe_n: 5'h1f, io_sel_n: 1'b1,
      sd_sel_n: 2'h3, sd_cmd: SD_CMD_NOP, sd_mask: 4'h0, data_out: 32'h00000000,
      data_oe: 4'h0, cb_out: 8'h00, cb_oe: 1'b0};

   emi_state_t  state_reg, state_next;
   emi_pins_t   pins_reg, pins_next;
   emi_req_t    cur_reg, cur_next;
   emi_rsp_t    rsp_reg, rsp_next;
   logic        rsp_valid_reg, rsp_valid_next;
   logic        ready_reg, ready_next;
   logic        gpio_reg;
   logic [9:0]  cnt_reg, cnt_next;
   logic [9:0]  refr_reg, refr_next;
   logic [41:0] meta_reg, sync_reg;

   ////////////////////////////////////////////////////////////////////////
   // Pin input synchronisers
   ////////////////////////////////////////////////////////////////////////

   wire logic [31:0] data_s;
   wire logic [7:0]  cb_s;
   wire logic        rdy_n_s;
   wire logic        bus_exception_n_n_s;

   assign {data_s, cb_s, rdy_n_s, bus_exception_n_n_s} = sync_reg;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= '1;
         sync_reg <= '1;
      end else begin
         meta_reg <= {data_in, check_bit_lines_in, access_ready_n, bus_exception_n};
         sync_reg <= meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Area decode
   ////////////////////////////////////////////////////////////////////////

   wire logic [2:0]  region;
   wire logic        is_prom, is_io, is_sram, is_sdram, narrow;
   wire logic [2:0]  bank;
   wire logic [1:0]  rom_sel_n_w;
   wire logic [4:0]  ram_sel_n_w;
   wire logic [1:0]  sd_sel_n_w;
   wire logic [3:0]  strobe_n_w, lane_oe_w;
   wire logic [31:0] wdata_w;
   wire logic [3:0]  data_oe_w;
   wire logic        refresh_due;
   wire logic        gpio_w;

   assign region   = cur_reg.addr[REGION_MSB:REGION_LSB];
   assign is_prom  = region == REGION_PROM;
   assign is_io    = region == REGION_IO;
   assign is_sram  = region == REGION_SRAM;
   assign is_sdram = (region == REGION_SDRAM) && cfg.sdram_en;
   assign narrow   = (is_prom && cfg.prom_8bit) || (is_sram && cfg.sram_8bit) ||
                     (is_io && cfg.io_8bit);
   // Bank numbers past the last one fold onto the last bank
   assign bank     = (cur_reg.addr[BANK_MSB:BANK_LSB] > SRAM_LAST) ? SRAM_LAST :
                     cur_reg.addr[BANK_MSB:BANK_LSB];

   assign rom_sel_n_w = is_prom ? ~(2'h1 << cur_reg.addr[PROM_HALF_BIT]) : 2'h3;
   assign ram_sel_n_w = is_sram ? ~(5'h01 << bank) : 5'h1f;
   assign sd_sel_n_w  = ~(2'h1 << cur_reg.addr[SD_BANK_BIT]);

   assign gpio_w      = cfg.prom_8bit && cfg.sram_8bit && cfg.io_8bit && !cfg.sdram_en;
   assign data_oe_w   = gpio_reg ? {lane_oe_w[3:2], 2'h0} : lane_oe_w;
   assign refresh_due = cfg.sdram_en && (refr_reg == CNT_ZERO);

   emi_lane_map u_lane_map (
      .size       (cur_reg.size),
      .addr_lo    (cur_reg.addr[1:0]),
      .narrow     (narrow),
      .wdata      (cur_reg.wdata),
      .strobe_n   (strobe_n_w),
      .lane_oe    (lane_oe_w),
      .wdata_lane (wdata_w)
   );

   ////////////////////////////////////////////////////////////////////////
   // Access sequencer
   ////////////////////////////////////////////////////////////////////////

   always_comb begin
      state_next     = state_reg;
      cur_next       = cur_reg;
      rsp_next       = rsp_reg;
      rsp_valid_next = 1'b0;
      cnt_next       = (cnt_reg == CNT_ZERO) ? CNT_ZERO : cnt_reg - 10'h001;
      refr_next      = (refr_reg == CNT_ZERO) ? CNT_ZERO : refr_reg - 10'h001;
      pins_next      = PINS_IDLE;
      pins_next.addr = pins_reg.addr;
      unique case (state_reg)
         ST_IDLE: begin
            if (req_valid && ready_reg) begin
               cur_next   = req;
               state_next = ST_START;
            end else if (refresh_due) begin
               pins_next.sd_sel_n = 2'h0;
               pins_next.sd_cmd   = SD_CMD_REF;
               cnt_next           = TRFC_CYC;
               refr_next          = REFR_CYC;
               state_next         = ST_SD_REF;
            end
         end
         ST_START: begin
            if (is_sdram) begin
               pins_next.addr     = 28'(cur_reg.addr >> SD_ROW_SHIFT);
               pins_next.sd_sel_n = sd_sel_n_w;
               pins_next.sd_cmd   = SD_CMD_ACT;
               cnt_next           = TRCD_CYC;
               state_next         = ST_SD_ACT;
            end else if (is_prom || is_io || is_sram) begin
               pins_next.addr      = cur_reg.addr[ADDR_PINS-1:0];
               pins_next.rom_sel_n = rom_sel_n_w;
               pins_next.ram_sel_n = ram_sel_n_w;
               pins_next.io_sel_n  = !is_io;
               if (cur_reg.write) begin
                  pins_next.write_n   = 1'b0;
                  pins_next.lane_we_n = strobe_n_w;
                  pins_next.data_out  = wdata_w;
                  pins_next.data_oe   = data_oe_w;
                  pins_next.cb_out    = {cfg.test_cb7, cur_reg.check};
                  pins_next.cb_oe     = 1'b1;
               end else begin
                  pins_next.oe_n     = 1'b0;
                  pins_next.read     = 1'b1;
                  pins_next.ram_oe_n = ram_sel_n_w;
               end
               state_next = ST_STATIC;
            end else begin
               // Unmapped area or disabled SDRAM answers with an error at once
               rsp_next       = '{rdata: 32'h00000000, rcheck: 8'h00, mem_error: 1'b1};
               rsp_valid_next = 1'b1;
               state_next     = ST_IDLE;
            end
         end
         ST_STATIC: begin
            if (!rdy_n_s) begin
               rsp_next       = '{rdata: data_s, rcheck: cb_s, mem_error: !bus_exception_n_n_s};
               rsp_valid_next = 1'b1;
               state_next     = ST_IDLE;
            end else begin
               pins_next = pins_reg;
            end
         end
         ST_SD_ACT: begin
            pins_next.sd_sel_n = pins_reg.sd_sel_n;
            if (cnt_reg == CNT_ZERO) begin
               pins_next.addr    = 28'(cur_reg.addr >> SD_COL_SHIFT);
               pins_next.sd_cmd  = cur_reg.write ? SD_CMD_WRITE : SD_CMD_READ;
               pins_next.sd_mask = cur_reg.write ? ~lane_oe_w : 4'h0;
               if (cur_reg.write) begin
                  pins_next.data_out = cur_reg.wdata;
                  pins_next.data_oe  = 4'hf;
                  pins_next.cb_out   = {cfg.test_cb7, cur_reg.check};
                  pins_next.cb_oe    = 1'b1;
               end
               cnt_next   = cur_reg.write ? CNT_ZERO : RD_WAIT;
               state_next = ST_SD_RW;
            end
         end
         ST_SD_RW: begin
            pins_next.sd_sel_n = pins_reg.sd_sel_n;
            if (cnt_reg == CNT_ZERO) begin
               rsp_next       = '{rdata: data_s, rcheck: cb_s, mem_error: !bus_exception_n_n_s};
               rsp_valid_next = 1'b1;
               pins_next.sd_cmd = SD_CMD_PRE;
               cnt_next         = TRP_CYC;
               state_next       = ST_SD_PRE;
            end
         end
         ST_SD_PRE, ST_SD_REF: begin
            pins_next.sd_sel_n = pins_reg.sd_sel_n;
            if (cnt_reg == CNT_ZERO) begin
               pins_next.sd_sel_n = 2'h3;
               state_next         = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // Ready stays low on the return from an access while refresh is due, so refresh goes first; in idle a request with ready high wins
      ready_next = (state_next == ST_IDLE) && !(refresh_due && state_reg != ST_IDLE);
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_reg     <= ST_IDLE;
         pins_reg      <= PINS_IDLE;
         cur_reg       <= '0;
         rsp_reg       <= '0;
         rsp_valid_reg <= 1'b0;
         ready_reg     <= 1'b0;
         cnt_reg       <= CNT_ZERO;
         refr_reg      <= REFR_CYC;
         gpio_reg      <= 1'b0;
      end else begin
         state_reg     <= state_next;
         pins_reg      <= pins_next;
         cur_reg       <= cur_next;
         rsp_reg       <= rsp_next;
         rsp_valid_reg <= rsp_valid_next;
         ready_reg     <= ready_next;
         cnt_reg       <= cnt_next;
         refr_reg      <= refr_next;
         gpio_reg      <= gpio_w;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin outputs
   ////////////////////////////////////////////////////////////////////////

   assign req_ready                 = ready_reg;
   assign rsp_valid                 = rsp_valid_reg;
   assign rsp                       = rsp_reg;
   assign gpio_owns_low_lanes       = gpio_reg;
   assign address_out               = pins_reg.addr;
   assign data_out                  = pins_reg.data_out;
   assign data_lane_oe              = pins_reg.data_oe;
   assign check_bit_lines_out       = pins_reg.cb_out;
   assign check_bit_lines_oe        = pins_reg.cb_oe;
   assign output_enable_n           = pins_reg.oe_n;
   assign read_strobe               = pins_reg.read;
   assign write_strobe_n            = pins_reg.write_n;
   assign byte_lane_write_strobe_n  = pins_reg.lane_we_n;
   assign boot_rom_select_n         = pins_reg.rom_sel_n;
   assign static_ram_bank_select_n  = pins_reg.ram_sel_n;
   assign static_ram_bank_oe_n      = pins_reg.ram_oe_n;
   assign io_area_select_n          = pins_reg.io_sel_n;
   assign sync_dram_bank_select_n   = pins_reg.sd_sel_n;
   assign {sync_dram_row_strobe_n, sync_dram_column_strobe_n, sync_dram_write_n} =
          pins_reg.sd_cmd;
   assign sync_dram_byte_mask       = pins_reg.sd_mask;
   // A register cannot copy a clock; this one output is the clock itself
   assign sync_dram_clock_out       = clock;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   ////////////////////////////////////////////////////////////////////////

   default clocking dflt @(posedge clock); endclocking
   default disable iff (!arst_n);

   property p_addr_hold;
      (state_reg == ST_IDLE) && (state_next == ST_IDLE) |=> $stable(address_out);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved while idle");

   property p_data_store_only;
      (|data_lane_oe) |-> cur_reg.write;
   endproperty
   a_data_store_only: assert property (p_data_store_only) else $error("data driven on read");

   property p_gpio_lanes;
      gpio_owns_low_lanes |-> (data_lane_oe[1:0] == 2'h0);
   endproperty
   a_gpio_lanes: assert property (p_gpio_lanes) else $error("low lanes driven for gpio");

   property p_cb_write;
      (state_reg == ST_STATIC) |-> (check_bit_lines_oe == cur_reg.write);
   endproperty
   a_cb_write: assert property (p_cb_write) else $error("check bits enable wrong");

   property p_cb7;
      $rose(check_bit_lines_oe) |-> (check_bit_lines_out[7] == $past(cfg.test_cb7));
   endproperty
   a_cb7: assert property (p_cb7) else $error("top check bit not test field");

   property p_read_pair;
      output_enable_n == !read_strobe;
   endproperty
   a_read_pair: assert property (p_read_pair) else $error("read strobes disagree");

   property p_wait;
      (state_reg == ST_STATIC) && rdy_n_s |=> (state_reg == ST_STATIC) && $stable(pins_reg);
   endproperty
   a_wait: assert property (p_wait) else $error("access ended while not ready");

   property p_narrow_lane;
      !write_strobe_n && narrow |-> (byte_lane_write_strobe_n == 4'he);
   endproperty
   a_narrow_lane: assert property (p_narrow_lane) else $error("narrow write off top lane");

   property p_rom_half;
      !boot_rom_select_n[0] |-> !cur_reg.addr[PROM_HALF_BIT] && boot_rom_select_n[1];
   endproperty
   a_rom_half: assert property (p_rom_half) else $error("wrong prom half selected");

   property p_bus_exception_n;
      (state_reg == ST_STATIC) && !rdy_n_s |=> rsp_valid && (rsp.mem_error == !$past(bus_exception_n_n_s));
   endproperty
   a_bus_exception_n: assert property (p_bus_exception_n) else $error("bus exception not reported");

   property p_sd_act_gap;
      (sync_dram_row_strobe_n == 1'b0) && sync_dram_column_strobe_n && sync_dram_write_n
         |=> (pins_reg.sd_cmd == SD_CMD_NOP) [*2];
   endproperty
   a_sd_act_gap: assert property (p_sd_act_gap) else $error("command too soon after act");

   c_read:    cover property ((state_reg == ST_STATIC) && !cur_reg.write ##1 rsp_valid);
   c_write:   cover property ((state_reg == ST_STATIC) && cur_reg.write ##1 rsp_valid);
   c_waits:   cover property ((state_reg == ST_STATIC) && rdy_n_s [*3]);
   c_refresh: cover property (state_reg == ST_SD_REF);

endmodule

/* File: src/emi_pkg.sv */
// Shared constants, types and states of the external memory pin interface
package emi_pkg;

   localparam int unsigned CLK_MHZ = 100;

   localparam int unsigned ADDR_PINS     = 28;
   localparam int unsigned REGION_MSB    = 31;
   localparam int unsigned REGION_LSB    = 29;
   localparam int unsigned PROM_HALF_BIT = 28;
   localparam int unsigned BANK_MSB      = 26;
   localparam int unsigned BANK_LSB      = 24;
   localparam int unsigned SD_BANK_BIT   = 28;
   localparam int unsigned SD_ROW_SHIFT  = 12;
   localparam int unsigned SD_COL_SHIFT  = 2;

   localparam logic [2:0] REGION_PROM  = 3'h0;
   localparam logic [2:0] REGION_IO    = 3'h1;
   localparam logic [2:0] REGION_SRAM  = 3'h2;
   localparam logic [2:0] REGION_SDRAM = 3'h3;
   localparam logic [2:0] SRAM_LAST    = 3'h4;

   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   // Row, column and write strobe levels of each SDRAM command
   localparam logic [2:0] SD_CMD_NOP   = 3'h7;
   localparam logic [2:0] SD_CMD_ACT   = 3'h3;
   localparam logic [2:0] SD_CMD_READ  = 3'h5;
   localparam logic [2:0] SD_CMD_WRITE = 3'h4;
   localparam logic [2:0] SD_CMD_PRE   = 3'h2;
   localparam logic [2:0] SD_CMD_REF   = 3'h1;

   localparam int unsigned SD_TRCD_NS    = 20;
   localparam int unsigned SD_TRP_NS     = 20;
   localparam int unsigned SD_TRFC_NS    = 70;
   localparam int unsigned SD_REFRESH_NS = 7800;
   localparam int unsigned SD_CAS_LAT    = 2;
   localparam int unsigned SYNC_DEPTH    = 2;

   localparam logic [9:0] TRCD_CYC = 10'((SD_TRCD_NS * CLK_MHZ + 999) / 1000);
   localparam logic [9:0] TRP_CYC  = 10'((SD_TRP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [9:0] TRFC_CYC = 10'((SD_TRFC_NS * CLK_MHZ + 999) / 1000);
   localparam logic [9:0] REFR_CYC = 10'((SD_REFRESH_NS * CLK_MHZ) / 1000);
   localparam logic [9:0] RD_WAIT  = 10'(SD_CAS_LAT + SYNC_DEPTH);
   localparam logic [9:0] CNT_ZERO = 10'h000;

   typedef struct packed {
      logic        write;
      logic [1:0]  size;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [6:0]  check;
   } emi_req_t;

   typedef struct packed {
      logic [31:0] rdata;
      logic [7:0]  rcheck;
      logic        mem_error;
   } emi_rsp_t;

   typedef struct packed {
      logic       prom_8bit;
      logic       sram_8bit;
      logic       io_8bit;
      logic       sdram_en;
      logic       test_cb7;
   } emi_cfg_t;

   typedef struct packed {
      logic [27:0] addr;
      logic        oe_n;
      logic        read;
      logic        write_n;
      logic [3:0]  lane_we_n;
      logic [1:0]  rom_sel_n;
      logic [4:0]  ram_sel_n;
      logic [4:0]  ram_oe_n;
      logic        io_sel_n;
      logic [1:0]  sd_sel_n;
      logic [2:0]  sd_cmd;
      logic [3:0]  sd_mask;
      logic [31:0] data_out;
      logic [3:0]  data_oe;
      logic [7:0]  cb_out;
      logic        cb_oe;
   } emi_pins_t;

   typedef enum logic [6:0] {
      ST_IDLE   = 7'h01,
      ST_START  = 7'h02,
      ST_STATIC = 7'h04,
      ST_SD_ACT = 7'h08,
      ST_SD_RW  = 7'h10,
      ST_SD_PRE = 7'h20,
      ST_SD_REF = 7'h40
   } emi_state_t;

endpackage

/* File: test/emi_mem_model.sv */
// Far-side memory and I/O device model with programmable wait states
`timescale 1ns/1ps
module emi_mem_model
   import emi_pkg::*;
#(
   parameter logic [31:0] RD_WORD = 32'hc3a5_5a3c
)
(
   input  wire logic        clock,
   input  wire logic        strobe,
   input  wire logic        oe_n,
   input  wire logic [3:0]  waits,
   input  wire logic        fault,
   output logic      [31:0] data_in,
   output logic      [7:0]  cb_in,
   output logic             ready_n,
   output logic             bus_exception_n_n
);
   //////////////////////////////
   logic [3:0] cnt;
   initial begin
      cnt = 4'h0;
      data_in = 32'h0;
      cb_in = 8'h0;
      ready_n = 1'b1;
      bus_exception_n_n = 1'b1;
   end
   // Released lines toggle so a stale value never looks valid
   always @(posedge clock) begin
      cnt <= strobe ? cnt + 4'h1 : 4'h0;
      ready_n <= !(strobe && cnt >= waits);
      bus_exception_n_n <= !(strobe && fault);
      data_in <= !oe_n ? RD_WORD : ~data_in;
      cb_in <= !oe_n ? 8'h5a : ~cb_in;
   end
endmodule

/* File: test/emi_pin_if_tb_top.sv */
// Self-checking bench for the external memory pin interface
`timescale 1ns/1ps
module emi_pin_if_tb_top;
   import emi_pkg::*;
   localparam logic [31:0] RDW = 32'hc3a5_5a3c;
   logic        clock = 1'b0;
   logic        arst_n = 1'b0;
   logic        req_valid = 1'b0;
   logic        fault = 1'b0;
   logic [3:0]  waits = 4'h2;
   emi_cfg_t    cfg = '0;
   emi_req_t    req = '0;
   logic        req_ready, rsp_valid, gpio_owns_low_lanes, check_bit_lines_oe;
   logic        output_enable_n, read_strobe, write_strobe_n, io_area_select_n;
   logic        sync_dram_clock_out, sync_dram_row_strobe_n, sync_dram_column_strobe_n;
   logic        sync_dram_write_n, access_ready_n, bus_exception_n;
   logic [1:0]  boot_rom_select_n, sync_dram_bank_select_n;
   logic [3:0]  data_lane_oe, byte_lane_write_strobe_n, sync_dram_byte_mask, wmask;
   logic [4:0]  static_ram_bank_select_n, static_ram_bank_oe_n;
   logic [7:0]  check_bit_lines_out, check_bit_lines_in;
   logic [27:0] address_out;
   logic [31:0] data_in, data_out;
   emi_rsp_t    rsp, got;
   emi_pins_t   pins, snap;
   int          errors = 0;
   int          check_count = 0;
   int          slen;
   //////////////////////////////
   emi_pin_if u_emi_pin_if (.clock, .arst_n, .cfg, .req_valid, .req, .req_ready,
      .rsp_valid, .rsp, .gpio_owns_low_lanes, .address_out, .data_in, .data_out,
      .data_lane_oe, .check_bit_lines_in, .check_bit_lines_out, .check_bit_lines_oe,
      .output_enable_n, .read_strobe, .write_strobe_n, .byte_lane_write_strobe_n,
      .access_ready_n, .bus_exception_n, .boot_rom_select_n, .static_ram_bank_select_n,
      .static_ram_bank_oe_n, .io_area_select_n, .sync_dram_clock_out,
      .sync_dram_bank_select_n, .sync_dram_row_strobe_n, .sync_dram_column_strobe_n,
      .sync_dram_write_n, .sync_dram_byte_mask);
   emi_mem_model #(.RD_WORD(RDW)) u_emi_mem_model (.clock,
      .strobe(read_strobe | ~write_strobe_n), .oe_n(output_enable_n), .waits, .fault,
      .data_in, .cb_in(check_bit_lines_in), .ready_n(access_ready_n),
      .bus_exception_n_n(bus_exception_n));
   assign pins = {address_out, output_enable_n, read_strobe, write_strobe_n,
      byte_lane_write_strobe_n, boot_rom_select_n, static_ram_bank_select_n,
      static_ram_bank_oe_n, io_area_select_n, sync_dram_bank_select_n,
      sync_dram_row_strobe_n, sync_dram_column_strobe_n, sync_dram_write_n,
      sync_dram_byte_mask, data_out, data_lane_oe, check_bit_lines_out, check_bit_lines_oe};
   always #5 clock = ~clock;
   //////////////////////////////
   task automatic check(input logic [39:0] g, input logic [39:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic tmo(input int n, input int lim = 300);
      if (n >= lim) begin
         errors++;
         end_sim();
      end
   endtask
   task automatic setup(input emi_cfg_t c, input logic [3:0] w, input logic f);
      @(posedge clock);
      cfg <= c;
      waits <= w;
      fault <= f;
   endtask
   // Snapshot taken at the first strobed cycle; the response at its pulse
   task automatic access(input logic w, input logic [1:0] sz, input logic [31:0] a,
                         input logic [31:0] wd);
      int n;
      logic seen;
      seen = 1'b0;
      slen = 0;
      wmask = 4'h5;
      n = 0;
      @(posedge clock);
      req_valid <= 1'b1;
      req <= {w, sz, a, wd, 7'h55};
      do begin
         @(negedge clock);
         n++;
      end while (req_ready !== 1'b1 && n < 300);
      tmo(n);
      @(posedge clock);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge clock);
         n++;
         if (read_strobe === 1'b1 || write_strobe_n === 1'b0) begin
            slen++;
            if (!seen)
               snap = pins;
            seen = 1'b1;
         end
         if (pins.sd_cmd === SD_CMD_ACT)
            snap.sd_sel_n = pins.sd_sel_n;
         if (pins.sd_cmd === SD_CMD_WRITE || pins.sd_cmd === SD_CMD_READ)
            wmask = pins.sd_mask;
      end while (rsp_valid !== 1'b1 && n < 300);
      tmo(n);
      got = rsp;
   endtask
   //////////////////////////////
   task automatic t_sram_write();
      setup(5'h01, 4'h3, 1'b0);
      access(1'b1, SIZE_WORD, 32'h4100_0008, 32'h1122_3344);
      check(snap.addr, 28'h100_0008);
      check({snap.ram_sel_n, snap.write_n, snap.lane_we_n}, 10'h3a0);
      check({snap.data_oe, snap.data_out}, {4'hf, 32'h1122_3344});
      check({snap.cb_oe, snap.cb_out}, 9'h1d5);
      check(slen > 3, 1'b1);
      repeat (4) @(negedge clock);
      check({address_out, data_lane_oe, check_bit_lines_oe}, {28'h100_0008, 4'h0, 1'b0});
      $display("test sram_write done");
   endtask
   task automatic t_prom_read();
      setup(5'h00, 4'h2, 1'b0);
      for (int h = 0; h < 2; h++) begin
         access(1'b0, SIZE_WORD, {3'h0, h[0], 28'h10}, 32'h0);
         check(snap.rom_sel_n, h ? 2'h1 : 2'h2);
         check({snap.oe_n, snap.read, snap.data_oe}, 6'h10);
         check({got.rdata, got.mem_error}, {RDW, 1'b0});
      end
      // Bank number 7 folds onto the last bank
      access(1'b0, SIZE_WORD, 32'h4700_0000, 32'h0);
      check({snap.ram_sel_n, snap.ram_oe_n}, 10'h1ef);
      check({got.rdata, got.mem_error}, {RDW, 1'b0});
      check({got.rcheck, got.mem_error}, 9'h0b4);
      $display("test prom_read done");
   endtask
   task automatic t_io_fault();
      setup(5'h00, 4'h2, 1'b1);
      access(1'b0, SIZE_WORD, 32'h2000_0004, 32'h0);
      check(snap.io_sel_n, 1'b0);
      check(got.mem_error, 1'b1);
      // Unmapped area errors at once and never strobes the bus
      access(1'b0, SIZE_WORD, 32'he000_0000, 32'h0);
      check({got.mem_error, slen > 0}, 2'h2);
      $display("test io_fault done");
   endtask
   task automatic t_narrow();
      setup(5'h1c, 4'h2, 1'b0);
      access(1'b1, SIZE_BYTE, 32'h4000_0001, 32'h00ab_0000);
      check(gpio_owns_low_lanes, 1'b1);
      check({snap.lane_we_n, snap.data_oe, snap.data_out[31:24]}, 16'he8ab);
      $display("test narrow done");
   endtask
   task automatic t_sdram();
      int n;
      setup(5'h1e, 4'h2, 1'b0);
      access(1'b1, SIZE_WORD, 32'h7000_1000, 32'hcafe_f00d);
      check({gpio_owns_low_lanes, snap.sd_sel_n, wmask}, 7'h10);
      access(1'b1, SIZE_HALF, 32'h6000_0002, 32'h0000_beef);
      check({snap.sd_sel_n, wmask}, 6'h2c);
      check(sync_dram_clock_out, 1'b0);
      #6;
      check(sync_dram_clock_out, 1'b1);
      access(1'b0, SIZE_WORD, 32'h7000_0000, 32'h0);
      check({snap.sd_sel_n, wmask, got.mem_error}, 7'h20);
      // Refresh must come on its own while the SDRAM sits idle
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (pins.sd_cmd !== SD_CMD_REF && n < 900);
      tmo(n, 900);
      check(sync_dram_bank_select_n, 2'h0);
      $display("test sdram done");
   endtask
   initial begin
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      t_sram_write();
      t_prom_read();
      t_io_fault();
      t_narrow();
      t_sdram();
      end_sim();
   end
endmodule
